// ### hdl/ddc_counter.sv
// one half of the dual decade ripple counter: divide-by-two plus divide-by-five
`timescale 1ns/1ns
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
// Functional notes
// - the divide-by-two and divide-by-five stages run on their own clock inputs and share only the clear.
// - in bi-quinary wiring div2_q is a square wave at a tenth of the input rate with half-period high.
// - in BCD wiring {div5_q, div2_q} steps 0 to 9, one step per input falling edge, then back to 0.
// - in bi-quinary wiring {div2_q, div5_q} reads 0 to 4 then 8 to 12, then wraps to 0.
// - each stage advances only on a falling edge of its own clock input, never on a rising one.
// - while clear is high both stages are held at zero, asynchronously, and nothing counts.
// - div5_q[2] is the most significant bit of the divide-by-five count.
module ddc_counter (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // stage clock pins and shared clear pin
  input  wire logic       clk_bi_pin,
  input  wire logic       clk_quin_pin,
  input  wire logic       clear_pin,
  // count outputs
  output logic            div2_q,
  output logic [2:0]      div5_q
);

  //////////////////////////////////////////////////////////////////////////////
  // stage clock edges

  logic fall_bi;
  logic fall_quin;
  logic arst_n;

  ddc_fall_det u_fall_bi (
    .mclk  (mclk),
    .rst_n (rst_n),
    .pin   (clk_bi_pin),
    .fall  (fall_bi)
  );

  ddc_fall_det u_fall_quin (
    .mclk  (mclk),
    .rst_n (rst_n),
    .pin   (clk_quin_pin),
    .fall  (fall_quin)
  );

  //////////////////////////////////////////////////////////////////////////////
  // counter state

  // clear acts without the clock; its release is resynchronised below
  assign arst_n = rst_n & ~clear_pin;

  ddc_pkg::ddc_state_t st_r;
  ddc_pkg::ddc_state_t st_nxt;
  logic                hold;

  // edges seen in the two cycles after clear drops are dropped too
  assign hold = st_r.clr_sync[1];

  always_comb
  begin
    st_nxt          = st_r;
    st_nxt.clr_sync = {st_r.clr_sync[0], 1'b0};
    if (!hold)
    begin
      // stages see only their own edge, so any outside chaining works
      if (fall_bi)
        st_nxt.bi = ~st_r.bi;
      if (fall_quin)
      begin
        if (st_r.quin == ddc_pkg::QUIN_LAST)
          st_nxt.quin = ddc_pkg::QUIN_ZERO;
        else
          st_nxt.quin = st_r.quin + ddc_pkg::QUIN_STEP;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r.clr_sync <= ddc_pkg::CLR_HOLD_RST;
      st_r.bi       <= ddc_pkg::BI_ZERO;
      st_r.quin     <= ddc_pkg::QUIN_ZERO;
    end
    else
      st_r <= st_nxt;
  end

  assign div2_q = st_r.bi;
  assign div5_q = st_r.quin;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  // combined codes as the two outside wirings read them
  // the wiring is outside, so only the code sets are checked here
  logic [3:0] bcd_code;
  logic [3:0] biq_code;
  assign bcd_code = {st_r.quin, st_r.bi};
  assign biq_code = {st_r.bi, st_r.quin};

  a_bi_toggle: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (fall_bi && !hold) |=> (st_r.bi != $past(st_r.bi)))
    else $error("divide-by-two stage missed a toggle");

  a_bi_indep: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (!fall_bi) |=> $stable(st_r.bi))
    else $error("divide-by-two stage moved without its own edge");

  a_quin_rise: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (!fall_quin) |=> $stable(st_r.quin))
    else $error("divide-by-five stage moved without a falling edge");

  a_quin_wrap: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (fall_quin && !hold && st_r.quin == ddc_pkg::QUIN_LAST) |=> (st_r.quin == ddc_pkg::QUIN_ZERO))
    else $error("divide-by-five stage did not wrap after four");

  a_quin_step: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (fall_quin && !hold && st_r.quin != ddc_pkg::QUIN_LAST)
      |=> (st_r.quin == $past(st_r.quin) + ddc_pkg::QUIN_STEP))
    else $error("divide-by-five stage did not step by one");

  a_clear_hold: assert property (
    @(posedge mclk) disable iff (!rst_n)
    clear_pin |=> (hold && st_r.bi == ddc_pkg::BI_ZERO && st_r.quin == ddc_pkg::QUIN_ZERO)[*2])
    else $error("outputs not held low around clear");

  a_msb_range: assert property (
    @(posedge mclk) disable iff (!arst_n)
    st_r.quin[ddc_pkg::QUIN_MSB] |-> (st_r.quin[1:0] == 2'h0))
    else $error("divide-by-five msb set with nonzero low bits");

  a_bcd_range: assert property (
    @(posedge mclk) disable iff (!arst_n)
    bcd_code <= ddc_pkg::BCD_MAX)
    else $error("bcd code above nine");

  a_biq_codes: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (biq_code <= ddc_pkg::BIQ_LOW_MAX)
      || (biq_code >= ddc_pkg::BIQ_HIGH_MIN && biq_code <= ddc_pkg::BIQ_HIGH_MAX))
    else $error("bi-quinary code outside its set");

  //////////////////////////////////////////////////////////////////////////////
  // clear, divide-by-five range and wrap, and pin edge checks

  // clear must act between clock edges, not wait for one
  a_clear_async: assert property (
    @(posedge mclk) disable iff (!rst_n)
    clear_pin |-> (div2_q == ddc_pkg::BI_ZERO && div5_q == ddc_pkg::QUIN_ZERO))
    else $error("outputs not low while clear is high");

  // edges right after clear are dropped, not queued
  a_hold_freeze: assert property (
    @(posedge mclk) disable iff (!arst_n)
    hold |=> ($stable(st_r.bi) && $stable(st_r.quin)))
    else $error("a stage counted inside the clear release hold");

  // release hold is exactly two edges long
  a_hold_len: assert property (
    @(posedge mclk) disable iff (!rst_n)
    $fell(clear_pin) |-> (hold ##1 hold ##1 !hold))
    else $error("clear release hold has the wrong length");

  // a code above four would miss the wrap at four and run on to seven before rolling over
  a_quin_range: assert property (
    @(posedge mclk) disable iff (!arst_n)
    st_r.quin <= ddc_pkg::QUIN_LAST)
    else $error("divide-by-five count above four");

  // the msb drop is what clocks a chained divide-by-two stage
  a_msb_drop: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (fall_quin && !hold && st_r.quin[ddc_pkg::QUIN_MSB]) |=> $fell(st_r.quin[ddc_pkg::QUIN_MSB]))
    else $error("divide-by-five msb did not drop on the wrap");

  // one pin edge gives one pulse, so a slow edge cannot count twice
  a_bi_once: assert property (
    @(posedge mclk) disable iff (!rst_n)
    fall_bi |=> !fall_bi)
    else $error("divide-by-two edge pulse longer than one cycle");

  // a pulse that never clears would count on every clock
  a_quin_once: assert property (
    @(posedge mclk) disable iff (!rst_n)
    fall_quin |=> !fall_quin)
    else $error("divide-by-five edge pulse longer than one cycle");

  // main scenarios: clear release, a counted divide-by-two edge, the divide-by-five wrap, bcd nine and bi-quinary twelve
  c_clear_hold: cover property (
    @(posedge mclk) disable iff (!rst_n)
    $fell(clear_pin));

  c_bi_toggle: cover property (
    @(posedge mclk) disable iff (!arst_n)
    fall_bi && !hold);

  c_quin_wrap: cover property (
    @(posedge mclk) disable iff (!arst_n)
    fall_quin && !hold && st_r.quin == ddc_pkg::QUIN_LAST);

  c_bcd_nine: cover property (
    @(posedge mclk) disable iff (!arst_n)
    bcd_code == ddc_pkg::BCD_MAX);

  c_biq_twelve: cover property (
    @(posedge mclk) disable iff (!arst_n)
    biq_code == ddc_pkg::BIQ_HIGH_MAX);

endmodule : ddc_counter

`default_nettype wire

// ### hdl/ddc_pkg.sv
// shared constants and types for the dual decade ripple counter half
package ddc_pkg;

  // divide-by-five stage: counts 0..QUIN_LAST, then wraps to QUIN_ZERO
  localparam logic [2:0] QUIN_ZERO    = 3'h0;
  localparam logic [2:0] QUIN_LAST    = 3'h4;
  localparam logic [2:0] QUIN_STEP    = 3'h1;
  localparam int         QUIN_MSB     = 2;
  // divide-by-two stage reset value
  localparam logic       BI_ZERO      = 1'b0;
  // clear release synchroniser: reset value holds counting off
  localparam logic [1:0] CLR_HOLD_RST = 2'h3;
  localparam logic [1:0] CLR_RELEASE  = 2'h0;
  // range limits of the combined codes in the two wirings
  localparam logic [3:0] BCD_MAX      = 4'h9;
  localparam logic [3:0] BIQ_LOW_MAX  = 4'h4;
  localparam logic [3:0] BIQ_HIGH_MIN = 4'h8;
  localparam logic [3:0] BIQ_HIGH_MAX = 4'hc;

  typedef struct packed {
    logic [1:0] clr_sync;
    logic       bi;
    logic [2:0] quin;
  } ddc_state_t;

  typedef struct packed {
    logic       sync;
    logic       prev;
    logic [1:0] meta;
  } ddc_edge_state_t;

endpackage : ddc_pkg

// ### hdl/ddc_fall_det.sv
// three-flop synchroniser and falling-edge detector for one stage clock pin
`timescale 1ns/1ns
`default_nettype none

module ddc_fall_det (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // pin in, pulse out
  input  wire logic pin,
  output logic      fall
);

  ddc_pkg::ddc_edge_state_t st_r;
  ddc_pkg::ddc_edge_state_t st_nxt;

  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.meta = {st_r.meta[0], pin};
    st_nxt.sync = st_r.meta[1];
    st_nxt.prev = st_r.sync;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // only high-to-low counts; rising edges are ignored
  assign fall = st_r.prev & ~st_r.sync;

endmodule : ddc_fall_det

`default_nettype wire

// ### bench/ddc_wire_model.sv
// far-side model: routes the count source and stage outputs to the stage clock pins
`timescale 1ns/1ns
`default_nettype none

module ddc_wire_model (
  // mode 0 bcd, 1 bi-quinary, 2 stages driven apart
  input  wire logic [1:0] mode,
  input  wire logic       src,
  input  wire logic       src2,
  // outputs fed back, stage clocks out
  input  wire logic       div2_q,
  input  wire logic [2:0] div5_q,
  output logic            clk_bi_pin,
  output logic            clk_quin_pin
);
  always_comb
  begin
    clk_bi_pin   = (mode == 2'h1) ? div5_q[2] : src;
    clk_quin_pin = (mode == 2'h0) ? div2_q : ((mode == 2'h1) ? src : src2);
  end
endmodule : ddc_wire_model

`default_nettype wire

// ### bench/ddc_counter_tb.sv
// testbench for one counter half in separate, bcd and bi-quinary wiring
`timescale 1ns/1ns
`default_nettype none

module ddc_counter_tb;
  logic       mclk      = 1'b0;
  logic       rst_n     = 1'b0;
  logic       clear_pin = 1'b0;
  logic [1:0] mode      = 2'h2;
  logic       src       = 1'b1;
  logic       src2      = 1'b1;
  logic       clk_bi_pin;
  logic       clk_quin_pin;
  logic       div2_q;
  logic [2:0] div5_q;
  int         n_fail    = 0;
  int         n_checks  = 0;

  initial
  begin
    forever #4 mclk = ~mclk;
  end

  ddc_wire_model i_ddc_wire_model (.mode(mode), .src(src), .src2(src2), .div2_q(div2_q),
    .div5_q(div5_q), .clk_bi_pin(clk_bi_pin), .clk_quin_pin(clk_quin_pin));
  ddc_counter i_ddc_counter (.mclk(mclk), .rst_n(rst_n), .clk_bi_pin(clk_bi_pin),
    .clk_quin_pin(clk_quin_pin), .clear_pin(clear_pin), .div2_q(div2_q), .div5_q(div5_q));

  //////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    if (n_fail == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  task automatic check_code(input logic [3:0] got, input logic [3:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_code

  // 12 cycles each level leaves room for a chained stage to ripple
  task automatic pulse(input logic sel);
    @(posedge mclk);
    if (sel)
      src2 <= 1'b0;
    else
      src <= 1'b0;
    repeat (12) @(posedge mclk);
    src  <= 1'b1;
    src2 <= 1'b1;
    repeat (12) @(posedge mclk);
    #1;
  endtask : pulse

  // mode changes only under clear, so routing glitches never count
  task automatic do_clear(input logic [1:0] m);
    @(posedge mclk);
    clear_pin <= 1'b1;
    mode      <= m;
    #1;
    check_code({div2_q, div5_q}, 4'h0);
    pulse(1'b0);
    pulse(1'b1);
    check_code({div2_q, div5_q}, 4'h0);
    @(posedge mclk);
    clear_pin <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask : do_clear

  task automatic sep_scn;
    for (int k = 1; k <= 6; k++)
    begin
      pulse(1'b1);
      check_code({div2_q, div5_q}, 4'(k % 5));
    end
    pulse(1'b0);
    check_code({div2_q, div5_q}, 4'h9);
  endtask : sep_scn

  task automatic bcd_scn;
    do_clear(2'h0);
    for (int k = 1; k <= 20; k++)
    begin
      pulse(1'b0);
      check_code({div5_q, div2_q}, 4'(k % 10));
    end
  endtask : bcd_scn

  task automatic biq_scn;
    do_clear(2'h1);
    for (int k = 1; k <= 20; k++)
    begin
      pulse(1'b0);
      check_code({div2_q, div5_q}, 4'((k % 10 < 5) ? k % 10 : k % 10 + 3));
    end
  endtask : biq_scn

  initial
  begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    sep_scn();
    bcd_scn();
    biq_scn();
    report_and_stop();
  end

  // hang guard
  initial
  begin
    #400000;
    n_fail++;
    report_and_stop();
  end
endmodule : ddc_counter_tb

`default_nettype wire
